//--- logic/ppp_defs.vh
// Constants for the parallel programming port: commands, actions, imprint
// layout, memory geometry and timing. Included by the port logic and its checker.
`ifndef PPP_DEFS_VH
`define PPP_DEFS_VH

`define PPP_CMD_ERASE 8'h80
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_WR_PROG 8'h10
`define PPP_CMD_WR_DATA 8'h11
`define PPP_CMD_RD_SIG 8'h08
`define PPP_CMD_RD_FUSE 8'h04
`define PPP_CMD_RD_PROG 8'h02
`define PPP_CMD_RD_DATA 8'h03
`define PPP_CMD_NOP 8'h00

`define PPP_ACT_ADDR 2'h0
`define PPP_ACT_DATA 2'h1
`define PPP_ACT_CMD 2'h2
`define PPP_ACT_IDLE 2'h3

`define PPP_IMP_SIG0 8'h00
`define PPP_IMP_CAL 8'h01
`define PPP_IMP_SIG1 8'h02
`define PPP_IMP_SIG2 8'h04
`define PPP_IMP_LAST 8'h2a

`define PPP_PWORD_MSB 4
`define PPP_PPAGE_LSB 5
`define PPP_PPAGE_MSB 10
`define PPP_DWORD_MSB 1
`define PPP_DPAGE_LSB 2
`define PPP_DPAGE_MSB 5

`define PPP_LOCK_RST 8'hff
`define PPP_FUSE_KEEP_BIT 3

`define PPP_CLK_NS 40
`define PPP_ENTRY_SETTLE_NS 100
`define PPP_ENTRY_SETTLE_CYC ((`PPP_ENTRY_SETTLE_NS + `PPP_CLK_NS - 1) / `PPP_CLK_NS)
`define PPP_PROG_CYC 16
`define PPP_ERASE_CYC 64

`endif

//--- logic/ppp_port.v
// Parallel high-voltage programming port: load decode, command decode,
// page buffers, memory write/erase, read mux and ready/busy.
// Assumes all programmer pins are asynchronous to mclk and are held well
// over several mclk periods (strobes at least 250 ns, i.e. > 6 cycles).
`timescale 1ns/100ps
`default_nettype none
`include "ppp_defs.vh"

module ppp_port #(
    parameter [7:0] SIG0 = 8'h5a, // Arbitrary identity value
    parameter [7:0] SIG1 = 8'h33, // Arbitrary identity value
    parameter [7:0] SIG2 = 8'h07, // Arbitrary identity value
    parameter [7:0] CAL_STORED = 8'h80,
    parameter [7:0] FUSE_LO_INIT = 8'h62,
    parameter [7:0] FUSE_HI_INIT = 8'hdf,
    parameter [7:0] FUSE_EXT_INIT = 8'hff
) (
    input wire mclk,
    input wire reset,
    input wire hv_reset,
    input wire load_strobe,
    input wire wr_n,
    input wire oe_n,
    input wire load_action_sel0,
    input wire load_action_sel1_or_byte_sel_hi2,
    input wire byte_sel_lo_hi,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output wire data_oe,
    output wire ready_busy_flag,
    output wire prog_mode,
    output reg [7:0] osc_trim_register
);
    localparam S_IDLE = 3'b001;
    localparam S_PROG = 3'b010;
    localparam S_ERASE = 3'b100;

    // Two-flop synchronisers; stage one is read only by stage two
    reg [6:0] s1_r;
    reg [6:0] s2_r;
    reg [7:0] d1_r;
    reg [7:0] d2_r;
    always @(posedge mclk) begin
        s1_r <= {hv_reset, load_strobe, wr_n, oe_n, load_action_sel0,
                 load_action_sel1_or_byte_sel_hi2, byte_sel_lo_hi};
        s2_r <= s1_r;
        d1_r <= data_in;
        d2_r <= d1_r;
    end
    wire hv = s2_r[6];
    wire ls = s2_r[5];
    wire wrn = s2_r[4];
    wire oen = s2_r[3];
    wire act_bit0 = s2_r[2];
    wire sel_second = s2_r[1];
    wire sel_first = s2_r[0];
    wire [3:0] entry_pins = {sel_first, sel_second, act_bit0, wrn};

    reg ls_d_r;
    reg wr_d_r;
    reg hv_d_r;
    always @(posedge mclk) begin
        ls_d_r <= ls;
        wr_d_r <= wrn;
        hv_d_r <= hv;
    end
    wire ls_rise = ls & ~ls_d_r;
    wire wr_fall = ~wrn & wr_d_r;
    wire hv_rise = hv & ~hv_d_r;

    // Entry qualification: pins must stay 0000 through the settle window
    reg mode_r;
    reg [3:0] settle_r;
    reg settling_r;
    always @(posedge mclk) begin
        if (reset || !hv) begin
            mode_r <= 1'b0;
            settling_r <= 1'b0;
            settle_r <= 4'h0;
        end else if (hv_rise) begin
            settling_r <= (entry_pins == 4'h0);
            settle_r <= 4'h0;
        end else if (settling_r) begin
            if (entry_pins != 4'h0) begin
                settling_r <= 1'b0;
            end else if (settle_r == `PPP_ENTRY_SETTLE_CYC - 1) begin
                settling_r <= 1'b0;
                mode_r <= 1'b1;
            end else begin
                settle_r <= settle_r + 4'h1;
            end
        end
    end
    assign prog_mode = mode_r;

    // Calibration copied to trim while reset is asserted
    always @(posedge mclk) begin
        if (reset) begin
            osc_trim_register <= CAL_STORED;
        end
    end

    reg [7:0] cmd_r;
    reg [7:0] addr_lo_r;
    reg [7:0] addr_hi_r;
    reg [7:0] dat_lo_r;
    reg [7:0] dat_hi_r;
    reg [7:0] fuse_lo_r;
    reg [7:0] fuse_hi_r;
    reg [7:0] fuse_ext_r;
    reg [7:0] lock_r;
    reg [2:0] state_r;
    reg [6:0] cnt_r;
    reg [5:0] erase_idx_r;
    reg wsess_r;

    reg [15:0] prog_mem [0:2047];
    reg [7:0] data_mem [0:63];
    reg [15:0] pbuf [0:31];
    reg [7:0] dbuf [0:3];

    wire [15:0] addr = {addr_hi_r, addr_lo_r};
    wire [4:0] pword = addr[`PPP_PWORD_MSB:0];
    wire [5:0] ppage = addr[`PPP_PPAGE_MSB:`PPP_PPAGE_LSB];
    wire [1:0] dword = addr[`PPP_DWORD_MSB:0];
    wire [3:0] dpage = addr[`PPP_DPAGE_MSB:`PPP_DPAGE_LSB];
    wire [1:0] action = {sel_second, act_bit0};
    wire busy = (state_r != S_IDLE);
    wire lock_wr_ok = lock_r[0];

    assign ready_busy_flag = ~busy;

    integer i;
    always @(posedge mclk) begin
        if (reset || !mode_r) begin
            cmd_r <= `PPP_CMD_NOP;
            addr_lo_r <= 8'h00;
            addr_hi_r <= 8'h00;
            dat_lo_r <= 8'h00;
            dat_hi_r <= 8'h00;
            state_r <= S_IDLE;
            cnt_r <= 7'h00;
            erase_idx_r <= 6'h00;
            wsess_r <= 1'b0;
        end else begin
            if (ls_rise && !busy) begin
                // Fields already synchronised; sampled on strobe rise
                case (action)
                    `PPP_ACT_ADDR: begin
                        if (sel_first) begin
                            addr_hi_r <= d2_r;
                        end else begin
                            addr_lo_r <= d2_r;
                        end
                    end
                    `PPP_ACT_DATA: begin
                        if (sel_first) begin
                            dat_hi_r <= d2_r;
                        end else begin
                            dat_lo_r <= d2_r;
                        end
                        // Page load: latched word goes to the buffer slot
                        if (cmd_r == `PPP_CMD_WR_PROG) begin
                            if (sel_first) begin
                                pbuf[pword] <= {d2_r, dat_lo_r};
                            end else begin
                                pbuf[pword] <= {dat_hi_r, d2_r};
                            end
                        end else if (cmd_r == `PPP_CMD_WR_DATA) begin
                            dbuf[dword] <= d2_r;
                        end
                    end
                    `PPP_ACT_CMD: begin
                        cmd_r <= d2_r;
                        wsess_r <= (d2_r != `PPP_CMD_NOP);
                    end
                    default: begin
                    end
                endcase
            end
            case (state_r)
                S_IDLE: begin
                    if (wr_fall) begin
                        case (cmd_r)
                            `PPP_CMD_ERASE: begin
                                state_r <= S_ERASE;
                                erase_idx_r <= 6'h00;
                                cnt_r <= 7'h00;
                            end
                            `PPP_CMD_WR_PROG, `PPP_CMD_WR_DATA, `PPP_CMD_WR_FUSE,
                            `PPP_CMD_WR_LOCK: begin
                                state_r <= S_PROG;
                                cnt_r <= 7'h00;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                S_PROG: begin
                    if (cnt_r == `PPP_PROG_CYC - 1) begin
                        state_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 7'h01;
                    end
                end
                S_ERASE: begin
                    if (cnt_r == `PPP_ERASE_CYC - 1) begin
                        state_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 7'h01;
                    end
                    erase_idx_r <= erase_idx_r + 6'h01;
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // Memory writes; erase sweeps one program page per cycle
    always @(posedge mclk) begin
        if (reset) begin
            fuse_lo_r <= FUSE_LO_INIT;
            fuse_hi_r <= FUSE_HI_INIT;
            fuse_ext_r <= FUSE_EXT_INIT;
            lock_r <= `PPP_LOCK_RST;
        end else if (state_r == S_IDLE && wr_fall && mode_r && wsess_r) begin
            case (cmd_r)
                `PPP_CMD_WR_PROG: begin
                    if (lock_wr_ok) begin
                        for (i = 0; i < 32; i = i + 1) begin
                            prog_mem[{ppage, i[4:0]}] <= pbuf[i];
                        end
                    end
                end
                `PPP_CMD_WR_DATA: begin
                    if (lock_wr_ok) begin
                        for (i = 0; i < 4; i = i + 1) begin
                            data_mem[{dpage, i[1:0]}] <= dbuf[i];
                        end
                    end
                end
                `PPP_CMD_WR_FUSE: begin
                    // Byte selects pick which fuse byte
                    if (lock_wr_ok) begin
                        if (sel_first && !sel_second) begin
                            fuse_hi_r <= dat_lo_r;
                        end else if (!sel_first && sel_second) begin
                            fuse_ext_r <= dat_lo_r;
                        end else begin
                            fuse_lo_r <= dat_lo_r;
                        end
                    end
                end
                `PPP_CMD_WR_LOCK: begin
                    lock_r <= lock_r & dat_lo_r; // Only erase or reset returns bits to 1
                end
                default: begin
                end
            endcase
        end else if (state_r == S_ERASE) begin
            for (i = 0; i < 32; i = i + 1) begin
                prog_mem[{erase_idx_r, i[4:0]}] <= 16'hffff;
            end
            if (fuse_hi_r[`PPP_FUSE_KEEP_BIT]) begin
                data_mem[erase_idx_r] <= 8'hff;
            end
            // Lock clears only once every program page is blank
            if (cnt_r == `PPP_ERASE_CYC - 1) begin
                lock_r <= `PPP_LOCK_RST;
            end
        end
    end

    // Read path; identity bytes ignore lock state
    reg [7:0] rd_nxt;
    reg [15:0] pw;
    always @* begin
        pw = prog_mem[{ppage, pword}];
        rd_nxt = 8'hff;
        case (cmd_r)
            `PPP_CMD_RD_SIG: begin
                if (sel_first) begin
                    rd_nxt = CAL_STORED;
                end else begin
                    case (addr_lo_r)
                        `PPP_IMP_SIG0: rd_nxt = SIG0;
                        `PPP_IMP_CAL: rd_nxt = CAL_STORED;
                        `PPP_IMP_SIG1: rd_nxt = SIG1;
                        `PPP_IMP_SIG2: rd_nxt = SIG2;
                        default: rd_nxt = 8'hff;
                    endcase
                end
            end
            `PPP_CMD_RD_FUSE: begin
                case ({sel_second, sel_first})
                    2'b00: rd_nxt = fuse_lo_r;
                    2'b11: rd_nxt = fuse_hi_r;
                    2'b10: rd_nxt = fuse_ext_r;
                    default: rd_nxt = lock_r;
                endcase
            end
            `PPP_CMD_RD_PROG: begin
                if (lock_r[1]) begin
                    rd_nxt = sel_first ? pw[15:8] : pw[7:0];
                end
            end
            `PPP_CMD_RD_DATA: begin
                if (lock_r[1]) begin
                    rd_nxt = data_mem[{dpage, dword}];
                end
            end
            default: rd_nxt = 8'hff;
        endcase
    end

    always @(posedge mclk) begin
        if (reset) begin
            data_out <= 8'h00;
        end else begin
            data_out <= rd_nxt;
        end
    end

    assign data_oe = mode_r & ~oen;
endmodule
`default_nettype wire

//--- dv/ppp_port_properties.sv
// Checker for the parallel programming port, bound to every instance.
// Sees only port pins; figures allow for the two-flop pin synchroniser.
`timescale 1ns/100ps
`default_nettype none
`include "ppp_defs.vh"
module ppp_port_properties #(
    parameter [7:0] CAL_STORED = 8'h80
) (
    input wire mclk,
    input wire reset,
    input wire hv_reset,
    input wire wr_n,
    input wire oe_n,
    input wire load_action_sel0,
    input wire load_action_sel1_or_byte_sel_hi2,
    input wire byte_sel_lo_hi,
    input wire data_oe,
    input wire ready_busy_flag,
    input wire prog_mode,
    input wire [7:0] osc_trim_register
);
    logic [7:0] busy_len_r;
    logic [7:0] busy_len_nxt;
    wire entry_zero;
    assign entry_zero = !(byte_sel_lo_hi | load_action_sel1_or_byte_sel_hi2 | load_action_sel0 | wr_n);
    always @* begin
        busy_len_nxt = ready_busy_flag ? 8'h00 : busy_len_r + 8'h01;
    end
    always @(posedge mclk) begin
        busy_len_r <= reset ? 8'h00 : busy_len_nxt;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_trim_reload:
        assert property (disable iff (1'b0) reset |=> osc_trim_register == CAL_STORED)
        else $error("trim not reloaded in reset");
    a_trim_held:
        assert property (!reset |=> $stable(osc_trim_register)) else $error("trim moved");
    a_reset_idle:
        assert property (disable iff (1'b0) reset |=> ready_busy_flag && !prog_mode && !data_oe)
        else $error("port not idle after reset");
    a_oe_drives:
        assert property ((prog_mode && hv_reset && !oe_n)[*4] |=> data_oe)
        else $error("bus not driven while enabled");
    a_oe_release:
        assert property (oe_n[*3] |=> !data_oe) else $error("bus driven while disabled");
    a_oe_mode:
        assert property (data_oe |-> prog_mode && !$past(oe_n, 2))
        else $error("bus driven outside mode or enable");
    a_busy_len:
        assert property ($rose(ready_busy_flag) |-> busy_len_r inside
            {[`PPP_PROG_CYC:`PPP_PROG_CYC + 1], [`PPP_ERASE_CYC:`PPP_ERASE_CYC + 1]})
        else $error("busy length wrong");
    a_busy_bounded:
        assert property ($fell(ready_busy_flag) |-> ##[1:70] ready_busy_flag)
        else $error("busy too long");
    a_busy_cause:
        assert property ($fell(ready_busy_flag) |-> !$past(wr_n, 2) && prog_mode)
        else $error("busy without write pulse");
    a_mode_entry:
        assert property ($rose(prog_mode) |-> $past(entry_zero, 2) && hv_reset)
        else $error("mode entered with pins set");
    a_mode_drop:
        assert property ((!hv_reset)[*4] |=> !prog_mode) else $error("mode without voltage");
endmodule
bind ppp_port ppp_port_properties #(.CAL_STORED(CAL_STORED)) i_ppp_port_properties (
    .mclk(mclk), .reset(reset), .hv_reset(hv_reset), .wr_n(wr_n), .oe_n(oe_n),
    .load_action_sel0(load_action_sel0),
    .load_action_sel1_or_byte_sel_hi2(load_action_sel1_or_byte_sel_hi2),
    .byte_sel_lo_hi(byte_sel_lo_hi), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
    .prog_mode(prog_mode), .osc_trim_register(osc_trim_register));
`default_nettype wire

//--- dv/ppp_prog_bfm.sv
// Programmer model driving the port's pins through tasks.
// Assumes a free-running mclk; pins change 1 ns after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module ppp_prog_bfm (
    input wire logic mclk,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic ready_busy_flag,
    output logic hv_reset,
    output logic load_strobe,
    output logic wr_n,
    output logic oe_n,
    output logic load_action_sel0,
    output logic load_action_sel1_or_byte_sel_hi2,
    output logic byte_sel_lo_hi,
    output logic [7:0] data_in
);
    initial begin
        {hv_reset, load_strobe, byte_sel_lo_hi} = 3'h0;
        {wr_n, oe_n, load_action_sel0, load_action_sel1_or_byte_sel_hi2} = 4'hf;
        data_in = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Eight cycles per level clears 250 ns and the pin synchroniser
    task automatic load(input logic [1:0] act, input logic s1, input logic [7:0] d);
        {load_action_sel1_or_byte_sel_hi2, load_action_sel0} = act;
        byte_sel_lo_hi = s1;
        data_in = d;
        hold(8);
        load_strobe = 1'b1;
        hold(8);
        load_strobe = 1'b0;
        hold(8);
    endtask
    // No new command until ready returns
    task automatic pulse_wr(output logic busy);
        int n;
        busy = 1'b0;
        wr_n = 1'b0;
        for (n = 0; n < 8; n++) begin
            hold(1);
            busy |= (ready_busy_flag === 1'b0);
        end
        wr_n = 1'b1;
        for (n = 0; n < 100 && ready_busy_flag !== 1'b1; n++) begin
            hold(1);
        end
        hold(2);
    endtask
    task automatic rd(input logic s2, input logic s1, output logic [7:0] d);
        load_action_sel1_or_byte_sel_hi2 = s2;
        byte_sel_lo_hi = s1;
        oe_n = 1'b0;
        data_in = ~data_in; // Released bus must not show a stale byte
        hold(8);
        d = (data_oe === 1'b1) ? data_out : 8'hxx;
        oe_n = 1'b1;
        hold(8);
    endtask
    task automatic enter(input logic glitch);
        int n;
        hv_reset = 1'b0;
        for (n = 0; n < 12; n++) begin
            load_strobe = ~load_strobe;
            hold(2);
        end
        {byte_sel_lo_hi, load_action_sel1_or_byte_sel_hi2, load_action_sel0, wr_n} = 4'h0;
        hold(4);
        hv_reset = 1'b1;
        if (glitch) begin
            hold(1);
            wr_n = 1'b1;
        end
        hold(1300);
        wr_n = 1'b1;
        {load_action_sel1_or_byte_sel_hi2, load_action_sel0} = 2'h3;
        hold(8);
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Testbench for the programming port: entry, reads, writes, erase, lock.
// Assumes the port holds the bound checker; the model drives every pin but mclk and reset.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam logic [7:0] SIG0 = 8'h3c; // Arbitrary identity value
    localparam logic [7:0] SIG1 = 8'h4d; // Arbitrary identity value
    localparam logic [7:0] SIG2 = 8'h5e; // Arbitrary identity value
    localparam logic [7:0] CAL = 8'h91;
    logic mclk, reset, b;
    logic [7:0] v;
    logic [7:0] sig_addr [3] = '{8'h00, 8'h02, 8'h04};
    logic [7:0] sig_val [3] = '{SIG0, SIG1, SIG2};
    int mismatches, total_checks, i;
    wire hv_reset, load_strobe, wr_n, oe_n, load_action_sel0, byte_sel_lo_hi;
    wire load_action_sel1_or_byte_sel_hi2, data_oe, ready_busy_flag, prog_mode;
    wire [7:0] data_in, data_out, osc_trim_register;
    ppp_port #(.SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2), .CAL_STORED(CAL), .FUSE_LO_INIT(8'h62),
        .FUSE_HI_INIT(8'hdf)) i_ppp_port (
        .mclk(mclk), .reset(reset), .hv_reset(hv_reset), .load_strobe(load_strobe),
        .wr_n(wr_n), .oe_n(oe_n), .load_action_sel0(load_action_sel0),
        .load_action_sel1_or_byte_sel_hi2(load_action_sel1_or_byte_sel_hi2),
        .byte_sel_lo_hi(byte_sel_lo_hi), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .ready_busy_flag(ready_busy_flag), .prog_mode(prog_mode),
        .osc_trim_register(osc_trim_register));
    ppp_prog_bfm i_ppp_prog_bfm (
        .mclk(mclk), .data_out(data_out), .data_oe(data_oe), .ready_busy_flag(ready_busy_flag),
        .hv_reset(hv_reset), .load_strobe(load_strobe), .wr_n(wr_n), .oe_n(oe_n),
        .load_action_sel0(load_action_sel0),
        .load_action_sel1_or_byte_sel_hi2(load_action_sel1_or_byte_sel_hi2),
        .byte_sel_lo_hi(byte_sel_lo_hi), .data_in(data_in));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_of_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_ppp_prog_bfm.load(2'h2, 1'b0, c);
    endtask
    task automatic lda(input logic hi, input logic [7:0] a);
        i_ppp_prog_bfm.load(2'h0, hi, a);
    endtask
    task automatic wr;
        i_ppp_prog_bfm.pulse_wr(b);
        chk1(b, 1'b1);
    endtask
    task automatic rdc(input logic s2, input logic s1, input logic [7:0] e);
        i_ppp_prog_bfm.rd(s2, s1, v);
        chk8(v, e);
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        end_of_test();
    end
    initial begin
        {mismatches, total_checks} = 0;
        reset = 1'b1;
        repeat (10) @(posedge mclk);
        #1;
        reset = 1'b0;
        chk8(osc_trim_register, CAL);
        chk1(ready_busy_flag, 1'b1);
        i_ppp_prog_bfm.enter(1'b1);
        chk1(prog_mode, 1'b0);
        i_ppp_prog_bfm.enter(1'b0);
        chk1(prog_mode, 1'b1);
        cmd(8'h08);
        for (i = 0; i < 3; i++) begin
            lda(1'b0, sig_addr[i]);
            rdc(1'b0, 1'b0, sig_val[i]);
        end
        rdc(1'b0, 1'b1, CAL);
        cmd(8'h04);
        rdc(1'b0, 1'b0, 8'h62);
        rdc(1'b1, 1'b1, 8'hdf);
        rdc(1'b1, 1'b0, 8'hff);
        rdc(1'b0, 1'b1, 8'hff);
        cmd(8'h40);
        i_ppp_prog_bfm.load(2'h1, 1'b0, 8'h5c);
        wr();
        cmd(8'h04);
        rdc(1'b0, 1'b0, 8'h5c);
        cmd(8'h80);
        wr();
        cmd(8'h10);
        lda(1'b0, 8'h21);
        i_ppp_prog_bfm.load(2'h1, 1'b0, 8'h34);
        i_ppp_prog_bfm.load(2'h1, 1'b1, 8'h12);
        lda(1'b1, 8'h00);
        wr();
        cmd(8'h00);
        cmd(8'h02);
        lda(1'b0, 8'h21);
        rdc(1'b0, 1'b0, 8'h34);
        rdc(1'b0, 1'b1, 8'h12);
        i_ppp_prog_bfm.load(2'h3, 1'b0, 8'h80);
        rdc(1'b0, 1'b0, 8'h34);
        lda(1'b0, 8'h01);
        rdc(1'b0, 1'b0, 8'hff);
        cmd(8'h11);
        lda(1'b0, 8'h05);
        i_ppp_prog_bfm.load(2'h1, 1'b0, 8'ha5);
        wr();
        cmd(8'h03);
        rdc(1'b0, 1'b0, 8'ha5);
        lda(1'b0, 8'h09);
        rdc(1'b0, 1'b0, 8'hff);
        cmd(8'h40);
        i_ppp_prog_bfm.load(2'h1, 1'b0, 8'hd7);
        i_ppp_prog_bfm.load(2'h1, 1'b1, 8'h00);
        wr();
        cmd(8'h20);
        i_ppp_prog_bfm.load(2'h1, 1'b0, 8'hfc);
        wr();
        cmd(8'h02);
        lda(1'b0, 8'h21);
        rdc(1'b0, 1'b0, 8'hff);
        cmd(8'h08);
        lda(1'b0, 8'h00);
        rdc(1'b0, 1'b0, SIG0);
        cmd(8'h80);
        wr();
        cmd(8'h04);
        rdc(1'b0, 1'b1, 8'hff);
        rdc(1'b0, 1'b0, 8'h5c);
        rdc(1'b1, 1'b1, 8'hd7);
        cmd(8'h03);
        lda(1'b0, 8'h05);
        rdc(1'b0, 1'b0, 8'ha5);
        end_of_test();
    end
endmodule
`default_nettype wire
